// >>> hw/fcri_regs.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcri_map.svh"
// Notes on behaviour
// - program width bit picks 32 or 64 bits
// - data cache flush only while cache off
// - instruction cache flush only while cache off
// - two bits switch caches on and off
// - wait states 0..3; codes 4..7 reserved
// - control unlock key register is write-only
// - option unlock key register is write-only
// - done flag set on success, write-one clears
// - protect fault flag, write-one clears
// - alignment fault flag, write-one clears
// - not-erased fault flag, write-one clears
// - busy follows operation, drops on error
// - wait register resets to 0x630
// - control register at 0x10, resets locked
// - block decoded at base, five word offsets
// - right key sequence clears lock bit
// - right option key sets option enable
// - erase start clears when busy clears
// - protect flag with enable raises fault interrupt
module fcri_regs
  import fcri_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire fcri_bus_t   bus,
  input  wire fcri_eng_t   eng,
  output var  logic [31:0] rdata,
  output var  logic [2:0]  wait_state_count,
  output var  logic        program_width_sel,
  output var  logic        data_cache_on,
  output var  logic        instr_cache_on,
  output var  logic        prefetch_on,
  output var  logic        data_cache_flush,
  output var  logic        instr_cache_flush,
  output var  logic        program_cmd,
  output var  logic        page_erase_cmd,
  output var  logic        mass_erase_cmd,
  output var  logic        option_program_cmd,
  output var  logic        option_erase_cmd,
  output var  logic        erase_start,
  output var  logic        ctl_locked,
  output var  logic        option_write_allowed,
  output var  logic        fault_irq,
  output var  logic        done_irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam logic [31:0] WS_RST  = `FCRI_WS_RST;
  localparam logic [31:0] CTL_RST = `FCRI_CTL_RST;
  fcri_state_t st_ff;       // Registered state
  fcri_state_t nxt_st;      // Next state
  logic        hit;         // Address inside the block
  logic [7:0]  ofs;         // Byte offset in the block
  logic        wr_ws;       // Write to wait register
  logic        wr_key;      // Write to control key
  logic        wr_option_unlock_word;    // Write to option key
  logic        wr_stat;     // Write to status
  logic        wr_ctl;      // Write to control
  logic        ctl_key_ok;  // Control unlock sequence done
  logic        opt_key_ok;  // Option unlock sequence done
  logic [3:0]  flags;       // Sticky status flags, bits 5..2
  logic [3:0]  flag_set;    // Hardware set per flag
  logic [3:0]  flag_clr;    // Software clear per flag
  logic        any_err;     // Error event this cycle
  logic [31:0] rd_word;     // Read mux output
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit      = (bus.addr[31:8] == `FCRI_BASE_HI);
  assign ofs      = bus.addr[7:0];
  assign wr_ws    = bus.wr && hit && (ofs == `FCRI_OFS_WS);
  assign wr_key   = bus.wr && hit && (ofs == `FCRI_OFS_KEY);
  assign wr_option_unlock_word = bus.wr && hit && (ofs == `FCRI_OFS_OPTION_UNLOCK_WORD);
  assign wr_stat  = bus.wr && hit && (ofs == `FCRI_OFS_STAT);
  assign wr_ctl   = bus.wr && hit && (ofs == `FCRI_OFS_CTL);
  // ----------------------------------------
  // Unlock sequence detectors
  // ----------------------------------------
  fcri_key_gate #(
    .KEY_FIRST  (`FCRI_KEY_A),
    .KEY_SECOND (`FCRI_KEY_B)
  ) u_ctl_key (
    .clk       (clk),
    .reset_n   (reset_n),
    .key_wr    (wr_key),
    .key_data  (bus.wdata),
    .key_match (ctl_key_ok)
  );
  fcri_key_gate #(
    .KEY_FIRST  (`FCRI_KEY_A),
    .KEY_SECOND (`FCRI_KEY_B)
  ) u_opt_key (
    .clk       (clk),
    .reset_n   (reset_n),
    .key_wr    (wr_option_unlock_word),
    .key_data  (bus.wdata),
    .key_match (opt_key_ok)
  );
  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  assign any_err  = eng.protect_hit || eng.align_fault || eng.not_erased;
  // Done only counts when no error comes with it
  assign flag_set = {eng.done && !any_err, eng.protect_hit,
                     eng.align_fault, eng.not_erased};
  assign flag_clr = wr_stat ? bus.wdata[`FCRI_ST_FLG_HI:`FCRI_ST_FLG_LO]
                            : 4'h0;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_flag
      fcri_flag u_flag (
        .clk     (clk),
        .reset_n (reset_n),
        .set_evt (flag_set[gi]),
        .clr_req (flag_clr[gi]),
        .flag    (flags[gi])
      );
    end
  endgenerate
  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    rd_word = 32'h00000000;
    if (hit)
    begin
      unique case (ofs)
        `FCRI_OFS_WS:
        begin
          // Reserved bits read back at their reset value
          rd_word                               = WS_RST;
          rd_word[`FCRI_WS_PGW]                 = st_ff.program_width_sel;
          rd_word[`FCRI_WS_DATA_CACHE_ON]                = st_ff.data_cache_on;
          rd_word[`FCRI_WS_INSTR_CACHE_ON]                = st_ff.instr_cache_on;
          rd_word[`FCRI_WS_PREFETCH_ON]                = st_ff.prefetch_on;
          rd_word[`FCRI_WS_WSC_HI:0]            = st_ff.wait_state_count;
        end
        `FCRI_OFS_STAT:
        begin
          rd_word[`FCRI_ST_BUSY]                = st_ff.busy;
          rd_word[`FCRI_ST_FLG_HI:`FCRI_ST_FLG_LO] = flags;
        end
        `FCRI_OFS_CTL:
        begin
          rd_word[`FCRI_CTL_DONE_IRQ_ENABLE]              = st_ff.done_irq_enable;
          rd_word[`FCRI_CTL_FAULT_IRQ_ENABLE]              = st_ff.fault_irq_enable;
          rd_word[`FCRI_CTL_OPTION_WRITE_ALLOWED]              = st_ff.option_write_allowed;
          rd_word[`FCRI_CTL_LK]                 = st_ff.ctl_locked;
          rd_word[`FCRI_CTL_START]              = st_ff.start;
          rd_word[`FCRI_CTL_OBER]               = st_ff.ober;
          rd_word[`FCRI_CTL_OBPG]               = st_ff.obpg;
          rd_word[`FCRI_CTL_MER]                = st_ff.mer;
          rd_word[`FCRI_CTL_PER]                = st_ff.per;
          rd_word[`FCRI_CTL_PG]                 = st_ff.pg;
        end
        // Key registers and holes read zero
        default: rd_word = 32'h00000000;
      endcase
    end
  end
  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    nxt_st                   = st_ff;
    // Read data stands one cycle only
    nxt_st.rdata             = bus.rd ? rd_word : 32'h00000000;
    nxt_st.data_cache_flush  = 1'b0;
    nxt_st.instr_cache_flush = 1'b0;
    // Wait-state register
    if (wr_ws)
    begin
      nxt_st.program_width_sel = bus.wdata[`FCRI_WS_PGW];
      nxt_st.data_cache_on     = bus.wdata[`FCRI_WS_DATA_CACHE_ON];
      nxt_st.instr_cache_on    = bus.wdata[`FCRI_WS_INSTR_CACHE_ON];
      nxt_st.prefetch_on       = bus.wdata[`FCRI_WS_PREFETCH_ON];
      // Reserved wait codes leave the field as it was
      if (bus.wdata[`FCRI_WS_WSC_HI:0] <= `FCRI_WS_WSC_MAX)
        nxt_st.wait_state_count = bus.wdata[`FCRI_WS_WSC_HI:0];
      // Flush only honoured while the cache is off
      if (!st_ff.data_cache_on)
        nxt_st.data_cache_flush = bus.wdata[`FCRI_WS_DATA_CACHE_FLUSH];
      if (!st_ff.instr_cache_on)
        nxt_st.instr_cache_flush = bus.wdata[`FCRI_WS_INSTR_CACHE_FLUSH];
    end
    // Control register, only while unlocked
    if (wr_ctl && !st_ff.ctl_locked)
    begin
      nxt_st.done_irq_enable  = bus.wdata[`FCRI_CTL_DONE_IRQ_ENABLE];
      nxt_st.fault_irq_enable = bus.wdata[`FCRI_CTL_FAULT_IRQ_ENABLE];
      nxt_st.mer              = bus.wdata[`FCRI_CTL_MER];
      nxt_st.per              = bus.wdata[`FCRI_CTL_PER];
      nxt_st.pg               = bus.wdata[`FCRI_CTL_PG];
      // Start is set-only from software
      if (bus.wdata[`FCRI_CTL_START]) nxt_st.start = 1'b1;
      // Option commands need the option unlock
      if (st_ff.option_write_allowed)
      begin
        nxt_st.ober = bus.wdata[`FCRI_CTL_OBER];
        nxt_st.obpg = bus.wdata[`FCRI_CTL_OBPG];
      end
      // Software may only clear option enable
      if (!bus.wdata[`FCRI_CTL_OPTION_WRITE_ALLOWED])
        nxt_st.option_write_allowed = 1'b0;
    end
    // Relock is accepted even while locked
    if (wr_ctl && bus.wdata[`FCRI_CTL_LK])
      nxt_st.ctl_locked = 1'b1;
    if (ctl_key_ok)
      nxt_st.ctl_locked = 1'b0;
    if (opt_key_ok)
      nxt_st.option_write_allowed = 1'b1;
    // Busy follows the engine, forced low on an error
    nxt_st.busy = eng.busy && !any_err;
    if (st_ff.busy && !nxt_st.busy)
      nxt_st.start = 1'b0;
    // Interrupt lines from flags and enables
    nxt_st.fault_irq = flags[2] && st_ff.fault_irq_enable;
    nxt_st.done_irq  = flags[3] && st_ff.done_irq_enable;
  end
  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_ff                      <= '0;
      st_ff.program_width_sel    <= WS_RST[`FCRI_WS_PGW];
      st_ff.data_cache_on        <= WS_RST[`FCRI_WS_DATA_CACHE_ON];
      st_ff.instr_cache_on       <= WS_RST[`FCRI_WS_INSTR_CACHE_ON];
      st_ff.prefetch_on          <= WS_RST[`FCRI_WS_PREFETCH_ON];
      st_ff.wait_state_count     <= WS_RST[`FCRI_WS_WSC_HI:0];
      st_ff.ctl_locked           <= CTL_RST[`FCRI_CTL_LK];
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata                = st_ff.rdata;
  assign wait_state_count     = st_ff.wait_state_count;
  assign program_width_sel    = st_ff.program_width_sel;
  assign data_cache_on        = st_ff.data_cache_on;
  assign instr_cache_on       = st_ff.instr_cache_on;
  assign prefetch_on          = st_ff.prefetch_on;
  assign data_cache_flush     = st_ff.data_cache_flush;
  assign instr_cache_flush    = st_ff.instr_cache_flush;
  assign program_cmd          = st_ff.pg;
  assign page_erase_cmd       = st_ff.per;
  assign mass_erase_cmd       = st_ff.mer;
  assign option_program_cmd   = st_ff.obpg;
  assign option_erase_cmd     = st_ff.ober;
  assign erase_start          = st_ff.start;
  assign ctl_locked           = st_ff.ctl_locked;
  assign option_write_allowed = st_ff.option_write_allowed;
  assign fault_irq            = st_ff.fault_irq;
  assign done_irq             = st_ff.done_irq;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_width;
    wr_ws |=> program_width_sel == $past(bus.wdata[`FCRI_WS_PGW]);
  endproperty
  a_width: assert property (p_width) else $error("width bit not taken");
  property p_dflush;
    wr_ws && bus.wdata[`FCRI_WS_DATA_CACHE_FLUSH] |=> data_cache_flush == !$past(data_cache_on);
  endproperty
  a_dflush: assert property (p_dflush) else $error("data flush gating");
  // Flush pulse only follows an honoured request, so it lasts one cycle
  property p_dflush_src;
    data_cache_flush |-> $past(wr_ws && bus.wdata[`FCRI_WS_DATA_CACHE_FLUSH] && !data_cache_on);
  endproperty
  a_dflush_src: assert property (p_dflush_src) else $error("flush without request");
  property p_iflush;
    wr_ws && bus.wdata[`FCRI_WS_INSTR_CACHE_FLUSH] && instr_cache_on |=> !instr_cache_flush;
  endproperty
  a_iflush: assert property (p_iflush) else $error("instr flush while on");
  property p_wsc;
    wr_ws && bus.wdata[`FCRI_WS_WSC_HI:0] > `FCRI_WS_WSC_MAX |=> $stable(wait_state_count);
  endproperty
  a_wsc: assert property (p_wsc) else $error("reserved wait code taken");
  property p_done;
    eng.done && !any_err ##1 !wr_stat [*2] |-> flags[3];
  endproperty
  a_done: assert property (p_done) else $error("done flag lost");
  property p_protect_win;
    eng.protect_hit && wr_stat && bus.wdata[4] |=> flags[2];
  endproperty
  a_protect_win: assert property (p_protect_win) else $error("clear beat set");
  property p_unlock;
    wr_key && bus.wdata == `FCRI_KEY_A ##1 wr_key && bus.wdata == `FCRI_KEY_B
      |=> !ctl_locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed");
  property p_locked_ctl;
    wr_ctl && ctl_locked && !ctl_key_ok |=> $stable(mass_erase_cmd) && $stable(page_erase_cmd);
  endproperty
  a_locked_ctl: assert property (p_locked_ctl) else $error("locked write took");
  property p_key_read;
    bus.rd && hit && (ofs == `FCRI_OFS_KEY || ofs == `FCRI_OFS_OPTION_UNLOCK_WORD) |=> rdata == 32'h00000000;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read not zero");
  property p_start_clr;
    $fell(st_ff.busy) |-> !erase_start;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start not cleared");
  property p_err_busy;
    any_err |=> !st_ff.busy;
  endproperty
  a_err_busy: assert property (p_err_busy) else $error("busy after error");
  property p_irq;
    flags[2] && st_ff.fault_irq_enable |=> fault_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("fault irq missing");
  // Relock is honoured whether or not the register is locked
  property p_relock;
    wr_ctl && bus.wdata[`FCRI_CTL_LK] |=> ctl_locked;
  endproperty
  a_relock: assert property (p_relock) else $error("relock ignored");
  // Option unlock sets the option enable
  property p_option_write_allowed;
    opt_key_ok |=> option_write_allowed;
  endproperty
  a_option_write_allowed: assert property (p_option_write_allowed) else $error("option enable not set");
  // Option commands hold while option writes are not allowed
  property p_ob_refused;
    wr_ctl && !option_write_allowed |=> $stable(option_program_cmd) && $stable(option_erase_cmd);
  endproperty
  a_ob_refused: assert property (p_ob_refused) else $error("option cmd taken");
  c_race:    cover property (eng.protect_hit && wr_stat);
  c_unlock:  cover property (ctl_key_ok);
  c_optkey:  cover property (opt_key_ok);
  c_flush:   cover property (data_cache_flush);
  c_erase:   cover property (erase_start ##[1:20] !erase_start);
endmodule : fcri_regs
`default_nettype wire

// >>> hw/fcri_map.svh
`ifndef FCRI_MAP_SVH
`define FCRI_MAP_SVH
// ----------------------------------------
// Register block placement
// ----------------------------------------
`define FCRI_BASE_HI     24'h400220
`define FCRI_OFS_WS      8'h00
`define FCRI_OFS_KEY     8'h04
`define FCRI_OFS_OPTION_UNLOCK_WORD   8'h08
`define FCRI_OFS_STAT    8'h0C
`define FCRI_OFS_CTL     8'h10
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FCRI_WS_RST      32'h00000630
`define FCRI_CTL_RST     32'h00000080
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCRI_WS_PGW      15
`define FCRI_WS_DATA_CACHE_FLUSH    12
`define FCRI_WS_INSTR_CACHE_FLUSH    11
`define FCRI_WS_DATA_CACHE_ON     10
`define FCRI_WS_INSTR_CACHE_ON     9
`define FCRI_WS_PREFETCH_ON     4
`define FCRI_WS_WSC_HI   2
`define FCRI_WS_WSC_MAX  3'h3
`define FCRI_ST_BUSY     0
`define FCRI_ST_FLG_LO   2
`define FCRI_ST_FLG_HI   5
`define FCRI_CTL_DONE_IRQ_ENABLE   12
`define FCRI_CTL_FAULT_IRQ_ENABLE   10
`define FCRI_CTL_OPTION_WRITE_ALLOWED   9
`define FCRI_CTL_LK      7
`define FCRI_CTL_START   6
`define FCRI_CTL_OBER    5
`define FCRI_CTL_OBPG    4
`define FCRI_CTL_MER     2
`define FCRI_CTL_PER     1
`define FCRI_CTL_PG      0
// ----------------------------------------
// Unlock keys (values arbitrary)
// ----------------------------------------
`define FCRI_KEY_A       32'h1234ABCD
`define FCRI_KEY_B       32'h5A5AC3C3
`endif

// >>> hw/fcri_pkg.sv
package fcri_pkg;
  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fcri_bus_t;
  // Events and level from the flash engine
  typedef struct packed {
    logic busy;
    logic done;
    logic protect_hit;
    logic align_fault;
    logic not_erased;
  } fcri_eng_t;
  // Key sequence phase
  typedef enum logic [0:0] {
    FCRI_KEY_IDLE  = 1'b0,
    FCRI_KEY_ARMED = 1'b1
  } fcri_key_phase_t;
  typedef struct packed { fcri_key_phase_t phase; } fcri_key_st_t;
  typedef struct packed { logic flag; } fcri_flag_st_t;
  // State of the register block, apart from the status flags and key phases
  typedef struct packed {
    logic [31:0] rdata;
    logic [2:0]  wait_state_count;
    logic        program_width_sel;
    logic        data_cache_on;
    logic        instr_cache_on;
    logic        prefetch_on;
    logic        data_cache_flush;
    logic        instr_cache_flush;
    logic        busy;
    logic        done_irq_enable;
    logic        fault_irq_enable;
    logic        option_write_allowed;
    logic        ctl_locked;
    logic        start;
    logic        ober;
    logic        obpg;
    logic        mer;
    logic        per;
    logic        pg;
    logic        fault_irq;
    logic        done_irq;
  } fcri_state_t;
endpackage : fcri_pkg

// >>> hw/fcri_key_gate.sv
`timescale 1ns/1ps
`default_nettype none
// Two-word unlock sequence detector
module fcri_key_gate
  import fcri_pkg::*;
#(
  parameter logic [31:0] KEY_FIRST  = 32'h0,
  parameter logic [31:0] KEY_SECOND = 32'h0
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        key_wr,
  input  wire logic [31:0] key_data,
  output var  logic        key_match
);
  fcri_key_st_t st_ff;  // Sequence phase
  fcri_key_st_t nxt_st; // Next phase
  // ----------------------------------------
  // Sequence tracking
  // ----------------------------------------
  always_comb
  begin
    nxt_st    = st_ff;
    key_match = 1'b0;
    if (key_wr)
    begin
      unique case (st_ff.phase)
        FCRI_KEY_IDLE:
        begin
          if (key_data == KEY_FIRST) nxt_st.phase = FCRI_KEY_ARMED;
        end
        FCRI_KEY_ARMED:
        begin
          // Wrong word restarts; a repeated first word stays armed
          key_match    = (key_data == KEY_SECOND);
          nxt_st.phase = FCRI_KEY_IDLE;
          if (key_data == KEY_FIRST) nxt_st.phase = FCRI_KEY_ARMED;
        end
      endcase
    end
  end
  // Phase register
  always_ff @(posedge clk)
  begin
    if (!reset_n) st_ff <= '{phase: FCRI_KEY_IDLE};
    else          st_ff <= nxt_st;
  end
endmodule : fcri_key_gate
`default_nettype wire

// >>> hw/fcri_flag.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky flag, set by hardware, cleared by writing one
module fcri_flag
  import fcri_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output var  logic flag
);
  fcri_flag_st_t st_ff;  // Flag state
  fcri_flag_st_t nxt_st; // Next flag state
  // Set wins over a clear in the same cycle
  always_comb
  begin
    nxt_st = st_ff;
    if (clr_req) nxt_st.flag = 1'b0;
    if (set_evt) nxt_st.flag = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n) st_ff <= '{flag: 1'b0};
    else          st_ff <= nxt_st;
  end
  assign flag = st_ff.flag;
endmodule : fcri_flag
`default_nettype wire

// >>> sim/tb_fcri_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcri_map.svh"
// ----------------------------------------
// Register block bench
// ----------------------------------------
module tb_fcri_regs
  import fcri_pkg::*;
;
  // Register addresses
  localparam logic [31:0] A_WS  = {`FCRI_BASE_HI, `FCRI_OFS_WS};
  localparam logic [31:0] A_KEY = {`FCRI_BASE_HI, `FCRI_OFS_KEY};
  localparam logic [31:0] A_OBK = {`FCRI_BASE_HI, `FCRI_OFS_OPTION_UNLOCK_WORD};
  localparam logic [31:0] A_ST  = {`FCRI_BASE_HI, `FCRI_OFS_STAT};
  localparam logic [31:0] A_CTL = {`FCRI_BASE_HI, `FCRI_OFS_CTL};
  logic        clk;       // System clock
  logic        reset_n;   // Synchronous reset
  fcri_bus_t   bus;       // Register port request
  fcri_eng_t   eng;       // Flash engine events
  logic [31:0] rdata;     // Read data
  logic [2:0]  wait_state_count;
  logic        program_width_sel, data_cache_on, instr_cache_on, prefetch_on;
  logic        data_cache_flush, instr_cache_flush, program_cmd, page_erase_cmd;
  logic        mass_erase_cmd, option_program_cmd, option_erase_cmd, erase_start;
  logic        ctl_locked, option_write_allowed, fault_irq, done_irq;
  int          n_errors;  // Mismatches seen
  int          tests_run; // Comparisons made
  fcri_regs fcri_regs_i (
    .clk(clk), .reset_n(reset_n), .bus(bus), .eng(eng), .rdata(rdata),
    .wait_state_count(wait_state_count), .program_width_sel(program_width_sel),
    .data_cache_on(data_cache_on), .instr_cache_on(instr_cache_on),
    .prefetch_on(prefetch_on), .data_cache_flush(data_cache_flush),
    .instr_cache_flush(instr_cache_flush), .program_cmd(program_cmd),
    .page_erase_cmd(page_erase_cmd), .mass_erase_cmd(mass_erase_cmd),
    .option_program_cmd(option_program_cmd), .option_erase_cmd(option_erase_cmd),
    .erase_start(erase_start), .ctl_locked(ctl_locked),
    .option_write_allowed(option_write_allowed), .fault_irq(fault_irq),
    .done_irq(done_irq)
  );
  // 50 MHz clock
  always #10 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle write, returns mid-cycle after it took effect
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(negedge clk);
  endtask : wr
  // One-cycle read, data judged in the following cycle
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd
  // One-cycle engine pulse: {done, protect, align, not_erased}
  task automatic ev(input logic [3:0] sel);
    @(posedge clk);
    {eng.done, eng.protect_hit, eng.align_fault, eng.not_erased} <= sel;
    @(posedge clk);
    {eng.done, eng.protect_hit, eng.align_fault, eng.not_erased} <= 4'h0;
    @(negedge clk);
  endtask : ev
  // Verdict and stop
  task automatic end_of_test;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, key reads, unmapped places
  task automatic t_reset;
    rd(A_WS, 32'h0000_0630);
    @(negedge clk);
    chk(rdata, 32'h0);
    rd(A_CTL, 32'h0000_0080);
    rd(A_ST, 32'h0);
    rd(A_KEY, 32'h0);
    rd(A_OBK, 32'h0);
    rd({`FCRI_BASE_HI, 8'h14}, 32'h0);
    rd(32'h4003_2000, 32'h0);
    chk({data_cache_on, instr_cache_on, prefetch_on, ctl_locked}, 4'hF);
  endtask : t_reset
  // Wait field, width, cache enables and flushes
  task automatic t_wait;
    wr(A_WS, 32'h0000_1E33); // Flush while caches on
    chk({data_cache_flush, instr_cache_flush}, 2'b00);
    rd(A_WS, 32'h0000_0633);
    wr(A_WS, 32'h0000_9827); // Caches off, reserved wait code
    chk({data_cache_flush, instr_cache_flush}, 2'b00);
    chk({program_width_sel, wait_state_count}, 4'hB);
    chk({data_cache_on, instr_cache_on, prefetch_on}, 3'b000);
    rd(A_WS, 32'h0000_8023);
    wr(A_WS, 32'h0000_1822); // Flush with caches off
    chk({data_cache_flush, instr_cache_flush}, 2'b11);
    @(negedge clk);
    chk({data_cache_flush, instr_cache_flush}, 2'b00);
    rd(A_WS, 32'h0000_0022);
    for (int i = 0; i < 4; i++)
    begin
      wr(A_WS, 32'h0000_0630 | i);
      chk(wait_state_count, i);
    end
    chk({data_cache_on, instr_cache_on, program_width_sel}, 3'b110);
  endtask : t_wait
  // Lock, key sequences and option enable
  task automatic t_lock;
    wr(A_CTL, 32'h0000_0001);
    rd(A_CTL, 32'h0000_0080);
    wr(A_KEY, `FCRI_KEY_A);
    wr(A_KEY, 32'h0);
    wr(A_KEY, `FCRI_KEY_B);
    chk(ctl_locked, 1'b1);
    // First word twice, then the second word back to back with it
    wr(A_KEY, `FCRI_KEY_A);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: A_KEY, wdata: `FCRI_KEY_A};
    @(posedge clk);
    bus.wdata <= `FCRI_KEY_B;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(negedge clk);
    chk(ctl_locked, 1'b0);
    wr(A_CTL, 32'h0000_1637); // Option bits refused without enable
    rd(A_CTL, 32'h0000_1407);
    chk({program_cmd, page_erase_cmd, mass_erase_cmd, option_program_cmd}, 4'hE);
    wr(A_OBK, `FCRI_KEY_A);
    wr(A_OBK, `FCRI_KEY_B);
    chk(option_write_allowed, 1'b1);
    wr(A_CTL, 32'h0000_1637);
    chk({option_program_cmd, option_erase_cmd}, 2'b11);
    rd(A_CTL, 32'h0000_1637);
    wr(A_CTL, 32'h0000_1400); // Option enable cleared by zero
    rd(A_CTL, 32'h0000_1400);
  endtask : t_lock
  // Status flags, write-one clear, interrupts
  task automatic t_flags;
    for (int i = 0; i < 4; i++)
    begin
      ev(4'h1 << i);
      rd(A_ST, 32'h4 << i);
      chk({done_irq, fault_irq}, {i == 3, i == 2});
      wr(A_ST, 32'h0);
      rd(A_ST, 32'h4 << i);
      wr(A_ST, 32'h4 << i);
      rd(A_ST, 32'h0);
    end
    // Hardware set in the same cycle as a software clear
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: A_ST, wdata: 32'h10};
    eng.protect_hit <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    eng.protect_hit <= 1'b0;
    rd(A_ST, 32'h10);
    wr(A_ST, 32'h10);
    rd(A_ST, 32'h0);
    chk(fault_irq, 1'b0);
  endtask : t_flags
  // Busy bit and erase start
  task automatic t_busy;
    wr(A_CTL, 32'h0000_1440);
    @(posedge clk);
    eng.busy <= 1'b1;
    rd(A_ST, 32'h1);
    chk(erase_start, 1'b1);
    @(posedge clk);
    eng.busy <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(erase_start, 1'b0);
    rd(A_ST, 32'h0);
    // Error while engine stays busy drops busy for a cycle
    @(posedge clk);
    eng.busy <= 1'b1;
    eng.protect_hit <= 1'b1;
    @(posedge clk);
    eng.protect_hit <= 1'b0;
    bus <= '{wr: 1'b0, rd: 1'b1, addr: A_ST, wdata: 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    eng.busy <= 1'b0;
    @(negedge clk);
    chk(rdata, 32'h10);
    wr(A_ST, 32'h10);
  endtask : t_busy
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    bus = '0;
    eng = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_wait();
    t_lock();
    t_flags();
    t_busy();
    end_of_test();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : tb_fcri_regs
`default_nettype wire
